// ### osc_bus_model.sv
`timescale 1ns/1ps
// system bus stand-in: acks after a set stall, faults when told to
module osc_bus_model (
  input wire logic clk,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [3:0] stall,
  input wire logic [1:0] fault,
  output logic bus_ack,
  output logic bus_err,
  output logic bus_abort,
  output logic bus_err_restartable,
  output logic [31:0] bus_rdata
);
  logic [3:0] wait_q; // cycles the request has stood
  logic wrote_q = 1'b1; // last finished transfer was a write
  logic [31:0] last_q = 32'h0; // idle bus shows its inverse, never stale
  logic ready; // stall has run out
  assign ready = bus_req && wait_q >= stall;
  assign bus_ack = ready && fault == 2'h0;
  assign bus_err = ready && fault[0];
  assign bus_abort = ready && fault[1];
  assign bus_err_restartable = 1'b0;
  // first read after the pushes returns the vector, the next the linkage
  assign bus_rdata = bus_ack ? (wrote_q ? 32'h0000_1000 : 32'h0000_2000)
                             : ~last_q;
  // stall counter restarts per transfer
  always_ff @(posedge clk) begin
    wait_q <= (bus_req && !ready) ? wait_q + 4'h1 : 4'h0;
    if (bus_ack) wrote_q <= bus_write;
    last_q <= bus_rdata;
  end
endmodule // osc_bus_model

// ### osc_ending.sv
`timescale 1ns/1ps
// classifies how an instruction ends when an exception is recognised
module osc_ending
  import osc_pkg::*;
(
  input wire logic [2:0] cause,
  input wire logic string_op,
  input wire logic at_boundary,
  output osc_end_t ending,
  output logic pc_is_current
);

  // boundary exceptions leave the previous instruction completed
  wire logic is_partial_src = (cause == OSC_CAUSE_INTR) ||
    (cause == OSC_CAUSE_ABORT) || (cause == OSC_CAUSE_DEBUG) ||
    (cause == OSC_CAUSE_RBERR);

  always_comb begin
    if (at_boundary) begin
      ending = OSC_END_COMPLETED;
    end else if (cause == OSC_CAUSE_NRBERR) begin
      ending = OSC_END_TERMINATED;
    end else if (string_op && is_partial_src) begin
      ending = OSC_END_PARTIAL;
    end else if (cause == OSC_CAUSE_TRAP && !string_op) begin
      // in-flight traps such as divide-by-zero finish the instruction
      ending = OSC_END_COMPLETED;
    end else begin
      ending = OSC_END_SUSPENDED;
    end
  end

  // suspended and partial endings restart the same instruction
  assign pc_is_current = (ending == OSC_END_SUSPENDED) ||
    (ending == OSC_END_PARTIAL);

endmodule // osc_ending

// ### osc_entry_seq.sv
`timescale 1ns/1ps
// walks the bus references of exception entry
module osc_entry_seq
  import osc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic direct_mode,
  input wire logic bus_ack,
  output osc_step_t step,
  output logic busy,
  output logic done
);

  osc_step_t step_q, step_d;
  logic busy_q; // sequence in progress

  // next step, skipping module steps in direct mode
  function automatic osc_step_t next_step(osc_step_t s, logic dm);
    case (s)
      OSC_STEP_PUSH_PC: next_step = OSC_STEP_PUSH_PSW;
      OSC_STEP_PUSH_PSW: next_step = dm ? OSC_STEP_RD_PC :
        OSC_STEP_PUSH_MOD;
      OSC_STEP_PUSH_MOD: next_step = OSC_STEP_RD_PC;
      OSC_STEP_RD_PC: next_step = dm ? OSC_STEP_DONE :
        OSC_STEP_RD_LINK;
      default: next_step = OSC_STEP_DONE;
    endcase
  endfunction

  // advance only when the current reference is acknowledged
  assign step_d = start ? OSC_STEP_PUSH_PC :
    (busy_q && bus_ack) ? next_step(step_q, direct_mode) : step_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_q <= OSC_STEP_DONE;
      busy_q <= 1'b0;
    end else begin
      step_q <= step_d;
      busy_q <= start || (busy_q && step_d != OSC_STEP_DONE);
    end
  end

  assign step = step_q;
  assign busy = busy_q;
  // every data reference done
  assign done = busy_q && bus_ack && step_d == OSC_STEP_DONE;

endmodule // osc_entry_seq

// ### osc_pkg.sv
package osc_pkg;

  // operating states, one-hot
  typedef enum logic [4:0] {
    OSC_ST_RESET = 5'h01,
    OSC_ST_EXEC  = 5'h02,
    OSC_ST_EXCP  = 5'h04,
    OSC_ST_WAIT  = 5'h08,
    OSC_ST_HALT  = 5'h10
  } osc_state_t;

  // instruction ending classes
  typedef enum logic [1:0] {
    OSC_END_COMPLETED = 2'h0,
    OSC_END_SUSPENDED = 2'h1,
    OSC_END_TERMINATED = 2'h2,
    OSC_END_PARTIAL = 2'h3
  } osc_end_t;

  // exception entry bus steps
  typedef enum logic [2:0] {
    OSC_STEP_PUSH_PC = 3'h0,
    OSC_STEP_PUSH_PSW = 3'h1,
    OSC_STEP_PUSH_MOD = 3'h2,
    OSC_STEP_RD_PC = 3'h3,
    OSC_STEP_RD_LINK = 3'h4,
    OSC_STEP_DONE = 3'h5
  } osc_step_t;

  // status codes presented on the system interface
  localparam logic [3:0] OSC_STAT_IDLE = 4'h0;
  localparam logic [3:0] OSC_STAT_BUSY = 4'h1;
  localparam logic [3:0] OSC_STAT_WAIT = 4'h3;
  localparam logic [3:0] OSC_STAT_HALT = 4'hF;

  // exception cause codes
  localparam logic [2:0] OSC_CAUSE_INTR = 3'h0;
  localparam logic [2:0] OSC_CAUSE_TRAP = 3'h1;
  localparam logic [2:0] OSC_CAUSE_RBERR = 3'h2;
  localparam logic [2:0] OSC_CAUSE_ABORT = 3'h3;
  localparam logic [2:0] OSC_CAUSE_DEBUG = 3'h4;
  localparam logic [2:0] OSC_CAUSE_NRBERR = 3'h5;

  localparam int OSC_DATA_W = 32;

endpackage

// ### osc_state_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - five operating states govern everything
// - reset input forces reset state anywhere
// - reset release goes straight to executing
// - recognised exception moves to exception processing
// - wait instruction moves to waiting state
// - push pc, psw, module; read pc, linkage
// - direct mode skips module push and linkage
// - all entry references done returns to executing
// - waiting state is idle, shows wait status
// - interrupt or debug in waiting enters exception
// - bus error during entry halts the cpu
// - halted shows status; only reset leaves
// - interrupts at boundaries; traps mid-instruction
// - four endings chosen by exception type
// - completed ending stacks next instruction address
// - return from trap resumes after completed one
// - fetch, read, compute, write, flags, advance pc
// - address pointer reads count as source reads
// - suspended ending stacks the instruction's own address
// - reset or fatal bus error terminates
module osc_state_ctrl
  import osc_pkg::*;
#(
  parameter int DATA_W = OSC_DATA_W
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rst_n_pin,
  // execution-side events
  input wire logic instr_boundary,
  input wire logic instr_string,
  input wire logic [DATA_W-1:0] instr_pc,
  input wire logic [DATA_W-1:0] next_pc,
  input wire logic wait_op,
  input wire logic return_from_trap_op,
  input wire logic return_from_interrupt_op,
  input wire logic [DATA_W-1:0] return_pc,
  input wire logic trap_req,
  input wire logic intr_req,
  input wire logic debug_req,
  input wire logic direct_mode,
  // register values to stack
  input wire logic [DATA_W-1:0] processor_status_word,
  input wire logic [DATA_W-1:0] module_base_register,
  input wire logic [DATA_W-1:0] stack_ptr,
  // system bus
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic bus_abort,
  input wire logic bus_err_restartable,
  input wire logic [DATA_W-1:0] bus_rdata,
  output logic bus_req,
  output logic bus_write,
  output logic [DATA_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  output logic [3:0] bus_status,
  // to execution pipeline
  output osc_state_t op_state,
  output logic exec_enable,
  output logic load_pc,
  output logic [DATA_W-1:0] new_pc,
  output logic [DATA_W-1:0] new_link,
  output osc_end_t last_ending
);

  // state register and its next value
  osc_state_t state_q; // operating state
  osc_state_t state_d; // next operating state
  logic [2:0] cause_d; // cause decoded fresh each cycle, only its ending kept
  // entry bookkeeping, all held in flip-flops
  logic [DATA_W-1:0] save_pc_q; // pc to be stacked
  logic [DATA_W-1:0] sp_q; // stack address during entry
  logic [DATA_W-1:0] new_pc_q; // service entry point read back
  logic [DATA_W-1:0] new_link_q; // module linkage read back
  logic load_pc_q; // one-cycle pc load toward the pipeline
  osc_end_t ending_q; // how the last interrupted instruction ended
  // trap or interrupt return bookkeeping
  logic [DATA_W-1:0] ret_pc_q; // pc handed back by a return
  logic ret_sel_q; // new_pc shows the return pc, not the entry pc
  // either reset source; the pin and the system input act alike
  wire logic in_reset = sys_rst || !rst_n_pin;

  // decode of the running instruction's exception
  // a fault only matters while a reference is on the bus
  wire logic bus_fault = bus_err || bus_abort;
  // interrupts wait for a boundary, traps and debug do not
  wire logic any_exc = trap_req || (intr_req && instr_boundary) ||
    debug_req || bus_fault;
  // the sleeping cpu answers interrupts and debug conditions only
  wire logic wake = intr_req || debug_req;
  // the wait instruction itself has finished, so a wake is on a boundary
  wire logic in_wait = state_q == OSC_ST_WAIT;
  // a return instruction hands its pc over unless an exception wins
  wire logic take_ret = state_q == OSC_ST_EXEC && !any_exc &&
    (return_from_trap_op || return_from_interrupt_op);

  // cause priority: bus faults first, then traps, debug, interrupt
  // only a non-restartable bus error ends an instruction for good
  assign cause_d = (bus_err && !bus_err_restartable) ? OSC_CAUSE_NRBERR :
    bus_err ? OSC_CAUSE_RBERR :
    bus_abort ? OSC_CAUSE_ABORT :
    trap_req ? OSC_CAUSE_TRAP :
    debug_req ? OSC_CAUSE_DEBUG : OSC_CAUSE_INTR;

  // ending of the instruction in flight, chosen by exception type
  osc_end_t ending;
  logic pc_is_current; // stacked pc points at the instruction itself

  // ending classifier: pure decode of cause and position
  osc_ending u_ending (
    .cause(cause_d),
    .string_op(instr_string),
    .at_boundary(instr_boundary || in_wait),
    .ending(ending),
    .pc_is_current(pc_is_current)
  );

  // entry sequencer handshake
  logic seq_start; // recognition strobe, one cycle
  osc_step_t step; // reference on the bus
  logic seq_busy; // entry references still to run
  logic seq_done; // last reference acknowledged this cycle

  // entry starts on recognition while executing, or on a wake while
  // waiting; a cut entry left by a halt is never resumed, only reset clears it
  assign seq_start = (state_q == OSC_ST_EXEC && any_exc) ||
    (state_q == OSC_ST_WAIT && wake);

  // entry sequencer: one step per acknowledged reference
  osc_entry_seq u_seq (
    .clk(clk),
    .sys_rst(in_reset), // the pin reset clears a cut entry as well
    .start(seq_start),
    .direct_mode(direct_mode),
    .bus_ack(bus_ack),
    .step(step),
    .busy(seq_busy),
    .done(seq_done)
  );

  // state transitions; reset itself is applied in the register below
  always_comb begin
    // hold by default, so every path assigns the next state
    state_d = state_q;
    case (state_q)
      OSC_ST_RESET: begin
        // release leads straight to executing, no other way out
        state_d = OSC_ST_EXEC;
      end
      OSC_ST_EXEC: begin
        // an exception outranks a wait met in the same cycle
        if (any_exc) begin
          state_d = OSC_ST_EXCP;
        end else if (wait_op) begin
          state_d = OSC_ST_WAIT;
        end
      end
      OSC_ST_EXCP: begin
        // a fault here leaves no way to reach a service procedure
        if (seq_busy && bus_fault) begin
          state_d = OSC_ST_HALT;
        end else if (seq_done) begin
          // every entry reference has been acknowledged
          state_d = OSC_ST_EXEC;
        end
      end
      OSC_ST_WAIT: begin
        // idle until an interrupt or a debug condition arrives
        if (wake) begin
          state_d = OSC_ST_EXCP;
        end
      end
      OSC_ST_HALT: begin
        // dead end; only the reset branch of the register leaves it
        state_d = OSC_ST_HALT;
      end
      default: begin
        // an illegal code recovers through reset
        state_d = OSC_ST_RESET;
      end
    endcase
  end

  // reset outranks every transition
  // the pin and the system reset share this branch, so neither can be
  // overridden by an exception or a wake in the same cycle
  always_ff @(posedge clk) begin
    if (in_reset) begin
      state_q <= OSC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // capture ending and stacked pc on recognition
  // reset cuts the running instruction short, so it reads as terminated
  always_ff @(posedge clk) begin
    if (in_reset) begin
      ending_q <= OSC_END_TERMINATED;
      save_pc_q <= '0;
    end else if (seq_start) begin
      // the pc to stack is fixed here; later input changes are ignored
      ending_q <= ending;
      // completed keeps next address, restartable keeps own
      save_pc_q <= pc_is_current ? instr_pc : next_pc;
    end
  end

  // stack pointer walks down as words are pushed
  // the caller's stack pointer is only read at recognition, so a change
  // on that input during entry does not tear the pushed frame
  always_ff @(posedge clk) begin
    if (in_reset) begin
      sp_q <= '0;
    end else if (seq_start) begin
      sp_q <= stack_ptr - DATA_W'(4);
    end else if (seq_busy && bus_ack && step <= OSC_STEP_PUSH_MOD) begin
      sp_q <= sp_q - DATA_W'(4);
    end
  end

  // read-back of new pc and linkage
  // each word is taken at the edge of its own acknowledge, and a
  // faulted reference is never acknowledged, so nothing stale is kept
  always_ff @(posedge clk) begin
    if (in_reset) begin
      new_pc_q <= '0;
      new_link_q <= '0;
    end else if (seq_busy && bus_ack && step == OSC_STEP_RD_PC) begin
      new_pc_q <= bus_rdata;
    end else if (seq_busy && bus_ack && step == OSC_STEP_RD_LINK) begin
      new_link_q <= bus_rdata;
    end
  end

  // entry end: the last reference was acknowledged without a fault
  wire logic entry_end = seq_done && state_q == OSC_ST_EXCP && !bus_fault;

  // pc load toward the pipeline: entry end, or a trap or interrupt return
  // a pulse of one cycle; the pipeline takes new_pc while it stands
  always_ff @(posedge clk) begin
    if (in_reset) begin
      load_pc_q <= 1'b0;
    end else begin
      load_pc_q <= entry_end || take_ret;
    end
  end

  // resumed pc; the stacked one was next or own address
  always_ff @(posedge clk) begin
    if (in_reset) begin
      ret_pc_q <= '0;
    end else if (take_ret) begin
      ret_pc_q <= return_pc;
    end
  end

  // which pc new_pc shows: a return picks its own, a new entry clears it
  // a return pc of zero is legal, so a flag selects, not the value
  always_ff @(posedge clk) begin
    if (in_reset) begin
      ret_sel_q <= 1'b0;
    end else if (take_ret) begin
      ret_sel_q <= 1'b1;
    end else if (seq_start) begin
      ret_sel_q <= 1'b0;
    end
  end

  // bus drive: only entry references, never in wait or halt
  // the three push steps come first in the step encoding
  wire logic step_is_push = step <= OSC_STEP_PUSH_MOD;
  // request and address stand until the acknowledge; pushed status and module words follow their inputs
  assign bus_req = seq_busy && state_q == OSC_ST_EXCP;
  assign bus_write = bus_req && step_is_push;
  assign bus_addr = step_is_push ? sp_q : new_pc_q;
  // write data follows the step: pc, status word, then module base
  assign bus_wdata = (step == OSC_STEP_PUSH_PC) ? save_pc_q :
    (step == OSC_STEP_PUSH_PSW) ? processor_status_word :
    module_base_register;

  // status codes identify wait and halt distinctly
  // busy marks an entry reference; idle covers executing and reset
  // wait and halt keep their code for as long as the state lasts
  assign bus_status = (state_q == OSC_ST_WAIT) ? OSC_STAT_WAIT :
    (state_q == OSC_ST_HALT) ? OSC_STAT_HALT :
    bus_req ? OSC_STAT_BUSY : OSC_STAT_IDLE;

  // instruction sequencing runs only while executing; fetch, operand
  // reads, writes and pc advance all stop outside that state
  assign exec_enable = state_q == OSC_ST_EXEC;
  assign op_state = state_q;
  assign load_pc = load_pc_q;
  // both sources are flip-flops, so new_pc settles no later than the edge that raises load_pc
  assign new_pc = ret_sel_q ? ret_pc_q : new_pc_q;
  // linkage and ending stand until the next entry overwrites them
  assign new_link = new_link_q;
  assign last_ending = ending_q;

endmodule // osc_state_ctrl

// ### osc_state_ctrl_asserts.sv
`timescale 1ns/1ps
// port-level watch on the operating state controller
module osc_state_ctrl_chk
  import osc_pkg::*;
#(
  parameter int DATA_W = OSC_DATA_W
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rst_n_pin,
  input wire logic wait_op,
  input wire logic trap_req,
  input wire logic intr_req,
  input wire logic debug_req,
  input wire logic [DATA_W-1:0] stack_ptr,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic bus_abort,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [DATA_W-1:0] bus_addr,
  input wire logic [3:0] bus_status,
  input wire osc_state_t op_state,
  input wire logic load_pc
);
  default clocking @(posedge clk); endclocking
  // either reset input cancels every check in flight, except chk_reset_holds, which only the pin cancels
  default disable iff (sys_rst || !rst_n_pin);
  chk_reset_holds: assert property (
    disable iff (!rst_n_pin) sys_rst |=> op_state == OSC_ST_RESET)
    else $error("reset state not entered");
  chk_release_exec: assert property (
    op_state == OSC_ST_RESET |=> op_state == OSC_ST_EXEC)
    else $error("release did not reach exec");
  chk_trap_taken: assert property (
    op_state == OSC_ST_EXEC && trap_req |=> op_state == OSC_ST_EXCP)
    else $error("trap not taken");
  chk_wait_taken: assert property (
    op_state == OSC_ST_EXEC && wait_op && !trap_req && !intr_req
    && !debug_req |=> op_state == OSC_ST_WAIT)
    else $error("wait not entered");
  chk_idle_quiet: assert property (
    op_state == OSC_ST_WAIT |-> !bus_req && bus_status == OSC_STAT_WAIT)
    else $error("bus active while waiting");
  chk_wait_wake: assert property (
    op_state == OSC_ST_WAIT && (intr_req || debug_req)
    |=> op_state == OSC_ST_EXCP)
    else $error("wait not woken");
  chk_fault_halt: assert property (
    op_state == OSC_ST_EXCP && bus_req && (bus_err || bus_abort)
    |=> op_state == OSC_ST_HALT)
    else $error("entry fault did not halt");
  chk_halt_stays: assert property (
    op_state == OSC_ST_HALT |=> op_state == OSC_ST_HALT
    && bus_status == OSC_STAT_HALT && !bus_req)
    else $error("halt left without reset");
  chk_first_push: assert property (
    op_state == OSC_ST_EXEC && trap_req
    |=> bus_req && bus_write && bus_addr == stack_ptr - 4)
    else $error("first push wrong");
  chk_req_stands: assert property (
    bus_req && !bus_ack && !bus_err && !bus_abort
    |=> bus_req && $stable(bus_addr) && $stable(bus_write))
    else $error("request dropped before answer");
  chk_load_after: assert property (
    op_state == OSC_ST_EXCP ##1 op_state == OSC_ST_EXEC |-> ##[0:1] load_pc)
    else $error("pc not loaded after entry");
endmodule // osc_state_ctrl_chk

bind osc_state_ctrl osc_state_ctrl_chk #(.DATA_W(DATA_W)) u_chk (.*);

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import osc_pkg::*;
  localparam logic [31:0] SP = 32'h0000_8000; // stack top
  localparam logic [31:0] PSW = 32'h0000_0A5C; // status word to stack
  localparam logic [31:0] MBR = 32'h0000_0300; // module base to stack
  logic clk = 1'b0, sys_rst = 1'b1, rst_n_pin = 1'b1;
  logic instr_boundary = 1'b0, instr_string = 1'b0, wait_op = 1'b0;
  logic return_from_trap_op = 1'b0, return_from_interrupt_op = 1'b0;
  logic trap_req = 1'b0, intr_req = 1'b0, debug_req = 1'b0;
  logic direct_mode = 1'b0;
  logic [31:0] instr_pc = 32'h0000_0100, next_pc = 32'h0000_0104;
  logic [31:0] return_pc = 32'h0, processor_status_word = PSW;
  logic [31:0] module_base_register = MBR, stack_ptr = SP;
  logic bus_ack, bus_err, bus_abort, bus_err_restartable;
  logic bus_req, bus_write, exec_enable, load_pc;
  logic [31:0] bus_rdata, bus_addr, bus_wdata, new_pc, new_link;
  logic [3:0] bus_status, stall = 4'h0; // stall sets partner latency
  logic [1:0] fault = 2'h0; // bit 0 bus error, bit 1 abort
  osc_state_t op_state;
  osc_end_t last_ending;
  int miscompares = 0, n_checks = 0;
  always #5 clk = ~clk;
  osc_state_ctrl DUT (.*);
  osc_bus_model u_bus (.*);
  // one comparison, counted
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // reset through the pin or the system input, then release
  task t_reset(input logic pin);
    @(negedge clk);
    if (pin) rst_n_pin = 1'b0;
    else sys_rst = 1'b1;
    cyc(2);
    chk(op_state, OSC_ST_RESET);
    chk(bus_req, 1'b0);
    chk(bus_status, OSC_STAT_IDLE);
    chk(last_ending, OSC_END_TERMINATED);
    sys_rst = 1'b0;
    rst_n_pin = 1'b1;
    cyc(1);
    chk(op_state, OSC_ST_EXEC);
    chk(exec_enable, 1'b1);
    chk(load_pc, 1'b0);
  endtask
  // follow every entry transfer; bounded wait per answer
  task entry(input logic dm, input logic [31:0] pc);
    int k, t;
    logic [31:0] w[3];
    w = '{pc, PSW, MBR};
    for (k = 0; k < (dm ? 3 : 5); k++) begin
      t = 0;
      while (bus_ack !== 1'b1 && t < 40) begin
        cyc(1);
        t++;
      end
      chk(t < 40, 1'b1);
      chk(bus_write, k < (dm ? 2 : 3));
      if (k < (dm ? 2 : 3)) begin
        chk(bus_addr, SP - 32'(4 * (k + 1)));
        chk(bus_wdata, w[k]);
      end
      cyc(1);
    end
    cyc(1);
    chk(op_state, OSC_ST_EXEC);
    chk(new_pc, 32'h0000_1000);
    if (!dm) chk(new_link, 32'h0000_2000);
  endtask
  // mid-instruction trap ends completed, stacks the next address
  task t_trap(input logic dm, input logic [3:0] st);
    direct_mode = dm;
    stall = st;
    next_pc = next_pc + 32'h10;
    trap_req = 1'b1;
    cyc(1);
    trap_req = 1'b0;
    chk(op_state, OSC_ST_EXCP);
    chk(last_ending, OSC_END_COMPLETED);
    entry(dm, next_pc);
  endtask
  // sleep, stay quiet, wake on interrupt or debug
  task t_wait(input logic dbg);
    wait_op = 1'b1;
    cyc(1);
    wait_op = 1'b0;
    chk(op_state, OSC_ST_WAIT);
    cyc(8);
    chk(exec_enable, 1'b0);
    chk(bus_status, OSC_STAT_WAIT);
    chk(bus_req, 1'b0);
    debug_req = dbg;
    intr_req = !dbg;
    cyc(1);
    intr_req = 1'b0;
    debug_req = 1'b0;
    chk(op_state, OSC_ST_EXCP);
    chk(last_ending, OSC_END_COMPLETED);
    entry(direct_mode, next_pc);
  endtask
  // interrupt waits for an instruction boundary
  task t_intr;
    intr_req = 1'b1;
    cyc(3);
    chk(op_state, OSC_ST_EXEC);
    instr_boundary = 1'b1;
    cyc(1);
    intr_req = 1'b0;
    instr_boundary = 1'b0;
    chk(op_state, OSC_ST_EXCP);
    chk(last_ending, OSC_END_COMPLETED);
    entry(direct_mode, next_pc);
  endtask
  // debug mid-instruction restarts it: its own address is stacked
  task t_mid(input logic str);
    instr_string = str;
    debug_req = 1'b1;
    cyc(1);
    debug_req = 1'b0;
    instr_string = 1'b0;
    chk(op_state, OSC_ST_EXCP);
    chk(last_ending, str ? OSC_END_PARTIAL : OSC_END_SUSPENDED);
    entry(direct_mode, instr_pc);
  endtask
  // a return hands its pc to the pipeline for one cycle
  task t_ret(input logic vec);
    return_pc = vec ? 32'h0000_0000 : next_pc;
    return_from_trap_op = !vec;
    return_from_interrupt_op = vec;
    cyc(1);
    return_from_trap_op = 1'b0;
    return_from_interrupt_op = 1'b0;
    chk(load_pc, 1'b1);
    chk(new_pc, return_pc);
    chk(op_state, OSC_ST_EXEC);
    cyc(1);
    chk(load_pc, 1'b0);
  endtask
  // fault on the first push halts; nothing but reset leaves
  task t_halt(input logic [1:0] f);
    stall = 4'h0;
    trap_req = 1'b1;
    cyc(1);
    trap_req = 1'b0;
    fault = f;
    cyc(1);
    fault = 2'h0;
    chk(op_state, OSC_ST_HALT);
    intr_req = 1'b1;
    trap_req = 1'b1;
    cyc(8);
    intr_req = 1'b0;
    trap_req = 1'b0;
    chk(op_state, OSC_ST_HALT);
    chk(bus_status, OSC_STAT_HALT);
    chk(exec_enable, 1'b0);
    chk(bus_req, 1'b0);
  endtask
  initial begin
    t_reset(1'b0);
    t_trap(1'b0, 4'h0);
    t_trap(1'b0, 4'h3);
    t_trap(1'b1, 4'h2);
    t_wait(1'b0);
    t_wait(1'b1);
    direct_mode = 1'b0;
    t_mid(1'b0);
    t_mid(1'b1);
    t_ret(1'b0);
    t_ret(1'b1);
    t_intr;
    t_halt(2'h1);
    t_reset(1'b1);
    t_halt(2'h2);
    t_reset(1'b0);
    t_trap(1'b0, 4'h1);
    print_verdict;
  end
  // hang guard, well past the couple of hundred cycles the run needs
  initial begin
    #100000;
    miscompares++;
    print_verdict;
  end
endmodule // testbench
